// *** logic/freq_counter_pkg.sv ***
// Constants, timing counts and state types for the gated frequency and time counter.
// Assumes a single 40 MHz system clock; every timing count below is derived from that rate.

package freq_counter_pkg;

   localparam int unsigned SYS_CLK_HZ     = 40_000_000;
   localparam int unsigned REF_HZ         = 10_000_000;
   localparam int unsigned REF_DIV        = SYS_CLK_HZ / REF_HZ;
   localparam int unsigned TB_DECADES     = 8;
   localparam int unsigned TB_TAPS        = TB_DECADES + 1;

   localparam int unsigned PULSE_NS       = 150;
   localparam int unsigned PULSE_CYC      =
      (PULSE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

   localparam int unsigned HOLD_MS        = 500;
   localparam int unsigned HOLD_CYC       = HOLD_MS * (SYS_CLK_HZ / 1000);

   localparam int unsigned DIGITS         = 9;
   localparam logic [3:0]  DIGIT_MAX      = 4'h9;
   localparam logic [3:0]  DIGIT_ZERO     = 4'h0;

   typedef enum logic [3:0] {
      SEQ_MEASURE = 4'b0001,
      SEQ_STROBE  = 4'b0010,
      SEQ_HOLD    = 4'b0100,
      SEQ_CLEAR   = 4'b1000
   } seq_state_t;

endpackage

// *** logic/bcd_decade.sv ***
// One BCD decade of the counting chain with its terminal-count flag.
// Assumes the step input is a single-cycle event in the sys_clk domain.
`timescale 1ns/1ps

module bcd_decade
   import freq_counter_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Control
   input  wire logic       clear,
   input  wire logic       step,
   // Count state
   output logic      [3:0] digit,
   output logic            carry,
   output logic            max_count_n
);

   wire at_max = (digit == DIGIT_MAX);

   assign carry       = step && at_max;
   assign max_count_n = !at_max;

   always_ff @(posedge sys_clk) begin
      if (rst || clear) begin
         digit <= DIGIT_ZERO;
      end else if (step) begin
         digit <= at_max ? DIGIT_ZERO : digit + 4'h1;
      end
   end

endmodule // bcd_decade

// *** logic/gated_frequency_time_counter.sv ***
// Control and counting core of a gated frequency and period counter with latched digits.
// Assumes a 40 MHz sys_clk, the measured signal arriving asynchronously on a pin, and
// the mode, timebase and suppression selections coming from slow front-panel switches.
`timescale 1ns/1ps

module gated_frequency_time_counter
   import freq_counter_pkg::*;
#(
   parameter int unsigned NUM_DIGITS  = DIGITS,
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
)(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // Measured signal and selections
   input  wire logic                      meas_in,
   input  wire logic                      time_mode,
   input  wire logic [3:0]                timebase_select,
   input  wire logic                      zero_suppress_select,
   // Display digits
   output logic      [NUM_DIGITS*4-1:0]   display_digits,
   output logic      [NUM_DIGITS-1:0]     digit_blank,
   output logic      [NUM_DIGITS-1:0]     zero_blank_out,
   // Control status
   output logic                           latch_strobe_n,
   output logic                           count_reset_n,
   output logic                           gate_toggle_flop,
   output logic                           stop_hold_flop,
   output logic                           timebase_out
);

   localparam int unsigned HOLD_W  = $clog2(HOLD_CYCLES + 1);
   localparam int unsigned PULSE_W = $clog2(PULSE_CYC + 1);

   generate
      if (NUM_DIGITS < 2 || NUM_DIGITS > 16) begin : g_bad_digits
         $error("NUM_DIGITS must lie between 2 and 16");
      end
      if (HOLD_CYCLES < 1) begin : g_bad_hold
         $error("HOLD_CYCLES must be at least one");
      end
   endgenerate

   // Input synchronisers. Only meas_s2, meas_prev and the other _s2 stages feed logic.
   logic meas_s1;
   logic meas_s2;
   logic meas_prev;
   logic tmode_s1;
   logic tmode_s2;
   logic zsup_s1;
   logic zsup_s2;
   logic [3:0] tbsel_s1;
   logic [3:0] tbsel_s2;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meas_s1   <= 1'b0;
         meas_s2   <= 1'b0;
         meas_prev <= 1'b0;
         tmode_s1  <= 1'b0;
         tmode_s2  <= 1'b0;
         zsup_s1   <= 1'b0;
         zsup_s2   <= 1'b0;
         tbsel_s1  <= 4'h0;
         tbsel_s2  <= 4'h0;
      end else begin
         meas_s1   <= meas_in;
         meas_s2   <= meas_s1;
         meas_prev <= meas_s2;
         tmode_s1  <= time_mode;
         tmode_s2  <= tmode_s1;
         zsup_s1   <= zero_suppress_select;
         zsup_s2   <= zsup_s1;
         tbsel_s1  <= timebase_select;
         tbsel_s2  <= tbsel_s1;
      end
   end

   // The measured signal is sampled at 40 MHz, so inputs above about 20 MHz alias.
   wire meas_fall = meas_prev && !meas_s2;

   // Timebase: a prescaler makes the 10 MHz reference tick, then eight decades divide it.
   logic [1:0]         ref_count;
   logic [TB_TAPS-1:0] tb_tick;
   logic [3:0]         tb_div [TB_DECADES];

   wire ref_wrap = (ref_count == 2'(REF_DIV - 1));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ref_count <= 2'h0;
      end else begin
         ref_count <= ref_wrap ? 2'h0 : ref_count + 2'h1;
      end
   end

   assign tb_tick[0] = ref_wrap;

   genvar t;
   generate
      for (t = 0; t < TB_DECADES; t++) begin : g_tb
         wire tb_at_max = (tb_div[t] == DIGIT_MAX);
         assign tb_tick[t+1] = tb_tick[t] && tb_at_max;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               tb_div[t] <= DIGIT_ZERO;
            end else if (tb_tick[t]) begin
               tb_div[t] <= tb_at_max ? DIGIT_ZERO : tb_div[t] + 4'h1;
            end
         end
      end
   endgenerate

   // Selections above the slowest tap fall back to 0.1 Hz.
   wire [3:0] tb_index = (tbsel_s2 > 4'(TB_DECADES)) ? 4'(TB_DECADES) : tbsel_s2;
   wire       tb_sel_tick = tb_tick[tb_index];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timebase_out <= 1'b0;
      end else begin
         timebase_out <= tb_sel_tick;
      end
   end

   // Gate and count event routing.
   wire gate_event  = tmode_s2 ? meas_fall : tb_sel_tick;
   wire count_event = tmode_s2 ? tb_sel_tick : meas_fall;
   wire toggle_en   = !stop_hold_flop;

   // Sequencer after the gate closes: strobe, display hold, clearing pulse.
   seq_state_t          seq;
   seq_state_t          next_seq;
   logic [PULSE_W-1:0]  pulse_count;
   logic [HOLD_W-1:0]   hold_count;

   wire pulse_done = (pulse_count == PULSE_W'(PULSE_CYC - 1));
   wire hold_done  = (hold_count == HOLD_W'(HOLD_CYCLES - 1));
   wire clearing   = (seq == SEQ_CLEAR);
   wire gate_close = gate_event && toggle_en && gate_toggle_flop;

   always_comb begin
      next_seq = seq;
      unique case (seq)
         SEQ_MEASURE: begin
            if (stop_hold_flop) begin
               next_seq = SEQ_STROBE;
            end
         end
         SEQ_STROBE: begin
            if (pulse_done) begin
               next_seq = SEQ_HOLD;
            end
         end
         SEQ_HOLD: begin
            if (hold_done) begin
               next_seq = SEQ_CLEAR;
            end
         end
         SEQ_CLEAR: begin
            if (pulse_done) begin
               next_seq = SEQ_MEASURE;
            end
         end
         default: begin
            next_seq = SEQ_MEASURE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seq <= SEQ_MEASURE;
      end else begin
         seq <= next_seq;
      end
   end

   // One counter times both 150 ns pulses; it restarts on each state change.
   always_ff @(posedge sys_clk) begin
      if (rst || next_seq != seq) begin
         pulse_count <= '0;
      end else if (!pulse_done) begin
         pulse_count <= pulse_count + PULSE_W'(1);
      end
   end

   // The hold timer stays cleared until the sequencer reaches SEQ_HOLD.
   always_ff @(posedge sys_clk) begin
      if (rst || !stop_hold_flop || seq != SEQ_HOLD) begin
         hold_count <= '0;
      end else if (!hold_done) begin
         hold_count <= hold_count + HOLD_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latch_strobe_n <= 1'b1;
         count_reset_n  <= 1'b1;
      end else begin
         latch_strobe_n <= !(next_seq == SEQ_STROBE);
         count_reset_n  <= !(next_seq == SEQ_CLEAR);
      end
   end

   // Control flops. The stop flop only reacts to the gate's falling transition.
   always_ff @(posedge sys_clk) begin
      if (rst || clearing) begin
         gate_toggle_flop <= 1'b0;
         stop_hold_flop   <= 1'b0;
      end else begin
         if (gate_event && toggle_en) begin
            gate_toggle_flop <= !gate_toggle_flop;
         end
         if (gate_close) begin
            stop_hold_flop <= 1'b1;
         end
      end
   end

   // Counting chain. Only the first decade sees the gate; the rest ripple.
   wire [NUM_DIGITS:0]     step;
   wire [NUM_DIGITS-1:0]   max_n;
   wire [NUM_DIGITS*4-1:0] count_value;
   wire [NUM_DIGITS:0]     blank_chain_n;

   assign step[0] = count_event && gate_toggle_flop;

   // A low chain input at the top digit starts suppression.
   assign blank_chain_n[NUM_DIGITS] = !zsup_s2;

   genvar d;
   generate
      for (d = 0; d < NUM_DIGITS; d++) begin : g_digit
         bcd_decade u_decade (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .clear       (clearing),
            .step        (step[d]),
            .digit       (count_value[d*4 +: 4]),
            .carry       (step[d+1]),
            .max_count_n (max_n[d])
         );

         wire latched_zero = (display_digits[d*4 +: 4] == DIGIT_ZERO);
         assign digit_blank[d]    = !blank_chain_n[d+1] && latched_zero;
         assign blank_chain_n[d]  = !digit_blank[d];
         assign zero_blank_out[d] = blank_chain_n[d];
      end
   endgenerate

   // One process owns the whole latch word, so no variable has several drivers.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         display_digits <= '0;
      end else if (!latch_strobe_n) begin
         display_digits <= count_value;
      end
   end

endmodule // gated_frequency_time_counter

// *** testbench/freq_counter_asserts.sv ***
// Concurrent checks on the control and display ports of the gated counter.
// Assumes one sys_clk domain with a synchronous, active-high rst.
`timescale 1ns/1ps

module freq_counter_asserts
   import freq_counter_pkg::*;
#(
   parameter int unsigned NUM_DIGITS  = DIGITS,
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
)(
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rst,
   // Watched outputs
   input wire logic [NUM_DIGITS*4-1:0] display_digits,
   input wire logic [NUM_DIGITS-1:0]   digit_blank,
   input wire logic [NUM_DIGITS-1:0]   zero_blank_out,
   input wire logic                    latch_strobe_n,
   input wire logic                    count_reset_n,
   input wire logic                    gate_toggle_flop,
   input wire logic                    stop_hold_flop
);
   int unsigned hold_cnt;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Counts the display time from the end of the strobe, so an early clear shows up.
   always_ff @(posedge sys_clk) begin
      if (rst || !latch_strobe_n) begin
         hold_cnt <= 0;
      end else if (count_reset_n) begin
         hold_cnt <= hold_cnt + 1;
      end
   end

   sequence s_strobe;
      !latch_strobe_n [*6] ##1 latch_strobe_n;
   endsequence
   sequence s_clear;
      !count_reset_n [*6] ##1 count_reset_n;
   endsequence

   AST_STROBE_PULSE: assert property ($rose(stop_hold_flop) |=> s_strobe)
      else $error("latch strobe is not one 150 ns pulse after stop");
   AST_STROBE_IN_STOP: assert property (!latch_strobe_n |-> stop_hold_flop)
      else $error("latch strobe low outside the stopped phase");
   AST_STOP_ON_CLOSE: assert property ($fell(gate_toggle_flop) |-> stop_hold_flop)
      else $error("gate closed without setting the stop flop");
   AST_GATE_LOCKED: assert property (stop_hold_flop |-> !gate_toggle_flop)
      else $error("gate opened while the stop flop is set");
   AST_OPEN_IDLE: assert property ($rose(gate_toggle_flop) |-> $past(stop_hold_flop) == 1'b0)
      else $error("gate opened without the toggle enable");
   AST_HOLD_TIME: assert property ($fell(count_reset_n) |->
      hold_cnt >= HOLD_CYCLES - 1 && hold_cnt <= HOLD_CYCLES + 3)
      else $error("display time before the clear pulse is wrong");
   AST_CLEAR_PULSE: assert property ($fell(count_reset_n) |-> s_clear)
      else $error("clear pulse is not 150 ns long");
   AST_CLEAR_DONE: assert property ($rose(count_reset_n) |->
      !stop_hold_flop && !gate_toggle_flop)
      else $error("control flops not cleared by the clear pulse");
   AST_DISPLAY_HOLD: assert property (latch_strobe_n && $past(latch_strobe_n) |->
      $stable(display_digits))
      else $error("display changed while the strobe is high");
   AST_BLANK_CHAIN: assert property (zero_blank_out == ~digit_blank)
      else $error("blank chain output disagrees with digit blanking");
   AST_BLANK_ZERO: assert property (digit_blank[NUM_DIGITS-1] |->
      display_digits[NUM_DIGITS*4-1 -: 4] == 4'h0)
      else $error("top digit blanked although it is not zero");
endmodule // freq_counter_asserts

bind gated_frequency_time_counter freq_counter_asserts #(
   .NUM_DIGITS(NUM_DIGITS), .HOLD_CYCLES(HOLD_CYCLES)) i_freq_counter_asserts (
   .sys_clk(sys_clk), .rst(rst), .display_digits(display_digits),
   .digit_blank(digit_blank), .zero_blank_out(zero_blank_out),
   .latch_strobe_n(latch_strobe_n), .count_reset_n(count_reset_n),
   .gate_toggle_flop(gate_toggle_flop), .stop_hold_flop(stop_hold_flop));

// *** testbench/meas_src.sv ***
// Behavioural source of the signal under measurement.
// Assumes the bench sets the half period in sys_clk cycles; zero parks the line high.
`timescale 1ns/1ps

module meas_src (
   // Clock
   input wire logic        sys_clk,
   // Shape
   input wire logic [15:0] half,
   // Measured signal
   output logic            meas_in
);
   logic [15:0] cnt;

   initial begin
      meas_in = 1'b1;
      cnt = 16'h0000;
   end

   always @(posedge sys_clk) begin
      #1;
      if (half == 16'h0000) begin
         meas_in = 1'b1;
         cnt = 16'h0000;
      end else if (cnt + 16'h0001 >= half) begin
         cnt = 16'h0000;
         meas_in = ~meas_in;
      end else begin
         cnt = cnt + 16'h0001;
      end
   end
endmodule // meas_src

// *** testbench/tb_top.sv ***
// Self-checking bench for the gated frequency and time counter.
// Assumes a shortened display time and four digits so every run stays brief.
`timescale 1ns/1ps

module tb_top;
   import freq_counter_pkg::*;
   localparam int ND = 4;
   logic sys_clk, rst, meas_in, time_mode, zero_suppress_select;
   logic latch_strobe_n, count_reset_n, timebase_out;
   logic [3:0] timebase_select, digit_blank;
   logic [15:0] half, display_digits;
   int err_total, comparisons, k, s, p, n;
   int per [5] = '{4, 8, 10, 20, 40};

   gated_frequency_time_counter #(.NUM_DIGITS(ND), .HOLD_CYCLES(20))
      i_gated_frequency_time_counter (
      .sys_clk(sys_clk), .rst(rst), .meas_in(meas_in), .time_mode(time_mode),
      .timebase_select(timebase_select), .zero_suppress_select(zero_suppress_select),
      .display_digits(display_digits), .digit_blank(digit_blank), .zero_blank_out(),
      .latch_strobe_n(latch_strobe_n), .count_reset_n(count_reset_n),
      .gate_toggle_flop(), .stop_hold_flop(), .timebase_out(timebase_out));
   meas_src i_meas_src (.sys_clk(sys_clk), .half(half), .meas_in(meas_in));

   task automatic summarize();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return latch_strobe_n;
         1: return count_reset_n;
         default: return timebase_out;
      endcase
   endfunction

   // Every wait is bounded; a run-out counts as a mismatch and ends the run.
   task automatic wt(input int w, input logic v);
      for (int i = 0; i < 20000; i++) begin
         if (pick(w) === v) return;
         @(posedge sys_clk);
         #1;
      end
      err_total++;
      $display("[ERR] t=%0t wait %0d timed out", $time, w);
      summarize();
   endtask

   function automatic logic [15:0] to_bcd(input int v);
      for (int i = 0; i < ND; i++) begin
         to_bcd[i*4+:4] = 4'((v / (10 ** i)) % 10);
      end
   endfunction

   function automatic logic [3:0] blank_exp(input logic [15:0] d, input logic zs);
      logic on;
      on = zs;
      for (int i = ND - 1; i >= 0; i--) begin
         blank_exp[i] = on && (d[i*4+:4] == 4'h0);
         on = blank_exp[i];
      end
   endfunction

   // The first cycle after a change is thrown away, since it may straddle the change.
   task automatic meas(input logic tm, input logic [3:0] sel, input logic [15:0] h,
                       input logic zs, input int v);
      time_mode = tm;
      timebase_select = sel;
      zero_suppress_select = zs;
      half = h;
      wt(1, 1'b0);
      wt(1, 1'b1);
      wt(0, 1'b0);
      wt(0, 1'b1);
      chk(32'(display_digits), 32'(to_bcd(v)));
      chk(32'(digit_blank), 32'(blank_exp(to_bcd(v), zs)));
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial begin
      rst = 1'b1;
      time_mode = 1'b0;
      timebase_select = 4'h0;
      zero_suppress_select = 1'b0;
      half = 16'h0002;
      err_total = 0;
      comparisons = 0;
      void'($urandom(23));
      repeat (3) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      for (s = 0; s < 4; s++) begin
         timebase_select = s[3:0];
         wt(2, 1'b1);
         @(posedge sys_clk);
         #1;
         wt(2, 1'b1);
         n = 0;
         do begin
            @(posedge sys_clk);
            #1;
            n++;
         end while (timebase_out !== 1'b1 && n < 9000);
         chk(32'(n), 32'(4 * (10 ** s)));
      end
      meas(1'b0, 4'h1, 16'h0000, 1'b1, 0);
      meas(1'b0, 4'h1, 16'h0000, 1'b0, 0);
      meas(1'b0, 4'h2, 16'h0002, 1'b1, 100);
      meas(1'b1, 4'h0, 16'h00c8, 1'b1, 100);
      meas(1'b1, 4'h1, 16'h00c8, 1'b0, 10);
      for (k = 0; k < 6; k++) begin
         s = 1 + $urandom % 2;
         p = per[$urandom % 5];
         meas(1'b0, s[3:0], 16'(p / 2), 1'($urandom % 2), (s == 1 ? 40 : 400) / p);
      end
      summarize();
   end
endmodule // tb_top
